// File: include/mic_pkg.sv
// mic_pkg: constants shared by the interrupt controller.
// assumes a 50 MHz system clock and an AHB-Lite register bus.
package mic_pkg;
    // register byte addresses (AHB word aligned)
    localparam logic [7:0] ADDR_CORE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PEN1 = 8'h04;
    localparam logic [7:0] ADDR_PEN2 = 8'h08;
    localparam logic [7:0] ADDR_PFLG1 = 8'h0C;
    localparam logic [7:0] ADDR_PFLG2 = 8'h10;
    localparam logic [7:0] ADDR_OPTION = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_SHADOW_BASE = 8'h20;
    localparam int SHADOW_COUNT = 7;
    // shadow slot index: accumulator, status, bank, ptr0 lo/hi, ptr1 lo, pc high
    localparam int SH_ACC = 0;
    localparam int SH_STATUS = 1;
    localparam int SH_BANK = 2;
    localparam int SH_PC_HIGH = 6;
    localparam logic [7:0] SHADOW_BANK_NUM = 8'h1F;
    // core control bit positions
    localparam int CC_GIE = 7;
    localparam int CC_PERIPH_GROUP_EN = 6;
    localparam int CC_T0E = 5;
    localparam int CC_PINE = 4;
    localparam int CC_IOCE = 3;
    localparam int CC_T0F = 2;
    localparam int CC_PINF = 1;
    localparam int CC_IOCF = 0;
    // writable and save masks, reset byte, vector address
    localparam logic [7:0] CORE_WR_MASK = 8'hFE;
    localparam logic [7:0] PEN2_MASK = 8'h89;
    localparam logic [7:0] PFLG1_WR_MASK = 8'hCF;
    localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [14:0] VECTOR_ADDR = 15'h0004;
    // instruction cycle: four Q phases of the system clock each
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q4 = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {
        MIC_RUN = 2'b00,
        MIC_SLEEP = 2'b01,
        MIC_WAKE_STEP = 2'b10,
        MIC_VECTOR = 2'b11
    } mic_state_type;
endpackage

// File: rtl/mic_irq_controller.sv
// mic_irq_controller: request flags, enables, vectoring, wake and context shadows.
// assumes one 50 MHz clock; q phases are derived here; the core consumes the
// vector request and pulses instruction/return/sleep events on this clock.
`timescale 1ns/10ps
module mic_irq_controller
    import mic_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic ext_pin_in,
    input wire logic timer0_ovf_in,
    input wire logic [7:0] pin_change_flag_reg_in,
    input wire logic [7:0] periph1_event_in,
    input wire logic serial_rx_flag_in,
    input wire logic serial_tx_flag_in,
    input wire logic [7:0] periph2_event_in,
    input wire logic [7:0] clockless_mask_in,
    input wire logic instr_done_in,
    input wire logic sleep_exec_in,
    input wire logic return_from_service_in,
    input wire logic [14:0] return_pc_in,
    input wire logic [7:0] ctx_acc_in,
    input wire logic [7:0] ctx_status_in,
    input wire logic [7:0] ctx_bank_in,
    input wire logic [7:0] ctx_ptr_in [4],
    input wire logic [7:0] ctx_pc_high_in,
    output logic vector_req_out,
    output logic flush_out,
    output logic [14:0] vector_addr_out,
    output logic [14:0] push_pc_out,
    output logic push_out,
    output logic restore_out,
    output logic [7:0] shadow_out [SHADOW_COUNT],
    output logic cpu_halted_out
);
    logic [1:0] q_phase_r;
    logic [7:0] core_r;
    logic [7:0] pen1_r;
    logic [7:0] pen2_r;
    logic [7:0] pflg1_r;
    logic [7:0] pflg2_r;
    logic edge_sel_r;
    logic [2:0] pin_sync_r;
    logic pin_edge;
    logic pin_flag_sampled_r;
    logic [7:0] shadow_r [SHADOW_COUNT];
    mic_state_type state_r;
    logic [1:0] lat_cnt_r;
    logic wake_armed_r;
    // bus
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;
    logic wr_core;
    logic wr_pen1;
    logic wr_pen2;
    logic wr_pflg1;
    logic wr_pflg2;
    logic wr_opt;
    logic [7:0] wd;
    logic pending_core;
    logic pending_periph;
    logic pending_any;
    logic wake_src;
    logic take;

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            q_phase_r <= Q1;
        else
            q_phase_r <= q_phase_r + 2'h1;
    end

    // bus slave: zero wait states, write data taken in data phase
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= RESET_BYTE;
        end
        else if (hready_in)
        begin
            wr_pend_r <= hsel_in && htrans_in == HTRANS_NONSEQ && hwrite_in;
            rd_pend_r <= hsel_in && htrans_in == HTRANS_NONSEQ && !hwrite_in;
            addr_r <= haddr_in;
        end
    end
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign wd = hwdata_in[7:0];

    always_comb
    begin
        wr_core = 1'b0;
        wr_pen1 = 1'b0;
        wr_pen2 = 1'b0;
        wr_pflg1 = 1'b0;
        wr_pflg2 = 1'b0;
        wr_opt = 1'b0;
        if (wr_pend_r && addr_r == ADDR_CORE_CTRL)
            wr_core = 1'b1;
        else if (wr_pend_r && addr_r == ADDR_PEN1)
            wr_pen1 = 1'b1;
        else if (wr_pend_r && addr_r == ADDR_PEN2)
            wr_pen2 = 1'b1;
        else if (wr_pend_r && addr_r == ADDR_PFLG1)
            wr_pflg1 = 1'b1;
        else if (wr_pend_r && addr_r == ADDR_PFLG2)
            wr_pflg2 = 1'b1;
        else if (wr_pend_r && addr_r == ADDR_OPTION)
            wr_opt = 1'b1;
    end

    // pin: three-stage sync, edge when stages two and three differ in the direction edge_sel_r selects
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            pin_sync_r <= 3'h0;
        else
            pin_sync_r <= {pin_sync_r[1:0], ext_pin_in};
    end
    assign pin_edge = edge_sel_r ? (pin_sync_r[1] && !pin_sync_r[2])
                                 : (!pin_sync_r[1] && pin_sync_r[2]);

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            edge_sel_r <= 1'b0;
        else if (wr_opt)
            edge_sel_r <= wd[0];
    end

    // core control: software value first, hardware sets override (set wins)
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            core_r <= RESET_BYTE;
        else
        begin
            core_r[CC_IOCF] <= |pin_change_flag_reg_in;
            if (wr_core)
            begin
                core_r[7:1] <= wd[7:1] & CORE_WR_MASK[7:1];
            end
            if (take)
                core_r[CC_GIE] <= 1'b0;
            else if (return_from_service_in)
                core_r[CC_GIE] <= 1'b1;
            if (timer0_ovf_in)
                core_r[CC_T0F] <= 1'b1;
            if (pin_edge)
                core_r[CC_PINF] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            pen1_r <= RESET_BYTE;
            pen2_r <= RESET_BYTE;
        end
        else
        begin
            if (wr_pen1)
                pen1_r <= wd;
            if (wr_pen2)
                pen2_r <= wd & PEN2_MASK;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            pflg1_r <= RESET_BYTE;
            pflg2_r <= RESET_BYTE;
        end
        else
        begin
            pflg1_r <= ((wr_pflg1 ? (wd & PFLG1_WR_MASK) : (pflg1_r & PFLG1_WR_MASK))
                       | (periph1_event_in & PFLG1_WR_MASK))
                       | {2'h0, serial_rx_flag_in, serial_tx_flag_in, 4'h0};
            pflg2_r <= ((wr_pflg2 ? wd : pflg2_r) | periph2_event_in) & PEN2_MASK;
        end
    end

    // pin flag seen by the vector logic only at Q1
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            pin_flag_sampled_r <= 1'b0;
        else if (q_phase_r == Q1)
            pin_flag_sampled_r <= core_r[CC_PINF];
    end

    // stale q1 sample must not outlive a software clear
    assign pending_core = (core_r[CC_T0E] && core_r[CC_T0F])
                       || (core_r[CC_PINE] && pin_flag_sampled_r && core_r[CC_PINF])
                       || (core_r[CC_IOCE] && core_r[CC_IOCF]);
    assign pending_periph = core_r[CC_PERIPH_GROUP_EN]
                         && (|(pen1_r & pflg1_r) || |(pen2_r & pflg2_r));
    assign pending_any = pending_core || pending_periph;
    assign wake_src = (|(pen1_r & pflg1_r & clockless_mask_in))
                   || (|(pen2_r & pflg2_r & clockless_mask_in))
                   || (core_r[CC_PINE] && core_r[CC_PINF])
                   || (core_r[CC_IOCE] && core_r[CC_IOCF]);
    // latency counted in instruction cycles, independent of instruction length
    assign take = state_r == MIC_VECTOR && q_phase_r == Q4 && lat_cnt_r == 2'h0;

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            state_r <= MIC_RUN;
            lat_cnt_r <= 2'h0;
            wake_armed_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                MIC_RUN:
                begin
                    if (sleep_exec_in && !(pending_any && core_r[CC_GIE]))
                        state_r <= MIC_SLEEP;
                    else if (pending_any && core_r[CC_GIE] && q_phase_r == Q4)
                    begin
                        state_r <= MIC_VECTOR;
                        lat_cnt_r <= 2'h1;
                    end
                end
                MIC_SLEEP:
                begin
                    if (wake_src)
                    begin
                        wake_armed_r <= core_r[CC_GIE];
                        state_r <= core_r[CC_GIE] ? MIC_WAKE_STEP : MIC_RUN;
                    end
                end
                MIC_WAKE_STEP:
                begin
                    if (instr_done_in)
                    begin
                        state_r <= MIC_VECTOR;
                        lat_cnt_r <= 2'h1;
                        wake_armed_r <= 1'b0;
                    end
                end
                default:
                begin
                    if (q_phase_r == Q4 && lat_cnt_r != 2'h0)
                        lat_cnt_r <= lat_cnt_r - 2'h1;
                    else if (take)
                        state_r <= MIC_RUN;
                end
            endcase
        end
    end

    assign vector_req_out = take;
    assign flush_out = take;
    assign push_out = take;
    assign restore_out = return_from_service_in;
    assign cpu_halted_out = state_r == MIC_SLEEP;

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            vector_addr_out <= VECTOR_ADDR;
            push_pc_out <= 15'h0000;
        end
        else if (take)
            push_pc_out <= return_pc_in;
    end

    // shadows: captured on vector, writable by software in bank 31
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < SHADOW_COUNT; i++)
                shadow_r[i] <= RESET_BYTE;
        end
        else if (take)
        begin
            shadow_r[SH_ACC] <= ctx_acc_in;
            shadow_r[SH_STATUS] <= ctx_status_in & STATUS_SAVE_MASK;
            shadow_r[SH_BANK] <= ctx_bank_in;
            for (int i = 0; i < 4; i++)
                shadow_r[SH_BANK + 1 + i] <= ctx_ptr_in[i];
            shadow_r[SH_PC_HIGH] <= ctx_pc_high_in;
        end
        else if (wr_pend_r && addr_r >= ADDR_SHADOW_BASE
                 && addr_r < ADDR_SHADOW_BASE + 8'(4 * SHADOW_COUNT))
            shadow_r[3'((addr_r - ADDR_SHADOW_BASE) >> 2)] <= wd;
    end
    assign shadow_out = shadow_r;

    // read data registered in the address phase
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            hrdata_out <= 32'h0000_0000;
        else if (hready_in && hsel_in && htrans_in == HTRANS_NONSEQ && !hwrite_in)
        begin
            hrdata_out <= 32'h0000_0000;
            if (haddr_in == ADDR_CORE_CTRL)
                hrdata_out[7:0] <= core_r;
            else if (haddr_in == ADDR_PEN1)
                hrdata_out[7:0] <= pen1_r;
            else if (haddr_in == ADDR_PEN2)
                hrdata_out[7:0] <= pen2_r;
            else if (haddr_in == ADDR_PFLG1)
                hrdata_out[7:0] <= pflg1_r;
            else if (haddr_in == ADDR_PFLG2)
                hrdata_out[7:0] <= pflg2_r;
            else if (haddr_in == ADDR_OPTION)
                hrdata_out[7:0] <= {7'h00, edge_sel_r};
            else if (haddr_in == ADDR_STATUS)
                hrdata_out[7:0] <= {SHADOW_BANK_NUM[4:0], wake_armed_r, state_r};
            else if (haddr_in >= ADDR_SHADOW_BASE
                     && haddr_in < ADDR_SHADOW_BASE + 8'(4 * SHADOW_COUNT))
                hrdata_out[7:0] <= shadow_r[3'((haddr_in - ADDR_SHADOW_BASE) >> 2)];
        end
    end

    a_gie_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        take |=> !core_r[CC_GIE]) else $error("global enable not cleared on vector");
    a_no_vec_gie: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_r == MIC_RUN && !core_r[CC_GIE]) |=> state_r != MIC_VECTOR)
        else $error("vector armed with global enable clear");
    a_pen2_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (pen2_r & ~PEN2_MASK) == 8'h00) else $error("unused enable bits set");
    a_timer_set: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        timer0_ovf_in |=> core_r[CC_T0F]) else $error("timer flag lost");
    a_summary_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (|pin_change_flag_reg_in) |=> core_r[CC_IOCF]) else $error("summary flag wrong");
    a_vec_latency: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(state_r == MIC_VECTOR) |-> ##[4:8] take)
        else $error("vector latency out of range");
    a_gie_return: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (return_from_service_in && !take) |=> core_r[CC_GIE]) else $error("return left enable clear");
    a_shadow_status: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        take |=> (shadow_r[SH_STATUS] & ~STATUS_SAVE_MASK) == 8'h00)
        else $error("timeout or sleep bits saved");
endmodule

// File: verification/mic_core_model.sv
// mic_core_model: behavioural core issuing instruction, sleep and return events.
// assumes the controller's vector request and halt status on the same clock.
`timescale 1ns/10ps
module mic_core_model
    import mic_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic vector_req_in,
    input wire logic halted_in,
    input wire logic [1:0] cmd_in,
    output logic instr_done_out,
    output logic sleep_exec_out,
    output logic ret_out,
    output logic [14:0] pc_out
);
    logic [1:0] ph_r;
    logic [1:0] cmd_r;
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            ph_r <= 2'h0;
        else
            ph_r <= ph_r + 2'h1;
    end
    // one instruction per four clocks, none while halted
    assign instr_done_out = (ph_r == 2'h3) && !halted_in;
    // sleep only after the bench has set the enables it wants
    assign sleep_exec_out = instr_done_out && (cmd_r == 2'h1);
    assign ret_out = instr_done_out && (cmd_r == 2'h2);
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            cmd_r <= 2'h0;
        else if (cmd_in != 2'h0)
            cmd_r <= cmd_in;
        else if (instr_done_out)
            cmd_r <= 2'h0;
    end
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            pc_out <= 15'h0000;
        else if (vector_req_in)
            pc_out <= VECTOR_ADDR;
        else if (instr_done_out)
            pc_out <= pc_out + 15'h0001;
    end
endmodule

// File: verification/tb_top.sv
// tb_top: register, flag, vectoring, context and sleep checks of the controller.
// assumes a zero-wait bus slave and the core model on the same clock.
`timescale 1ns/10ps
module tb_top;
    import mic_pkg::*;
    logic clk, rst_n, hsel, hwrite, hrdy, pin, t0, srx, stx, rfs, idone, sexe, vreq, flush, push, halt, rest, hresp;
    logic [1:0] htrans, cmd;
    logic [7:0] haddr, pchg, p1, p2, acc, st, bank, pch, cl;
    logic [7:0] ptr [4];
    logic [7:0] ex [5];
    logic [7:0] sh [SHADOW_COUNT];
    logic [14:0] rpc, vaddr, ppc, exp_pc;
    logic [31:0] hwdata, hrdata, rd;
    int err_count, n_tests, n_vec, n, ni, e, i;

    mic_irq_controller dut_u (.clk_sys_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .ext_pin_in(pin), .timer0_ovf_in(t0),
        .pin_change_flag_reg_in(pchg), .periph1_event_in(p1), .serial_rx_flag_in(srx),
        .serial_tx_flag_in(stx), .periph2_event_in(p2), .clockless_mask_in(cl), .instr_done_in(idone),
        .sleep_exec_in(sexe), .return_from_service_in(rfs), .return_pc_in(rpc), .ctx_acc_in(acc),
        .ctx_status_in(st), .ctx_bank_in(bank), .ctx_ptr_in(ptr), .ctx_pc_high_in(pch),
        .vector_req_out(vreq), .flush_out(flush), .vector_addr_out(vaddr), .push_pc_out(ppc),
        .push_out(push), .restore_out(rest), .shadow_out(sh), .cpu_halted_out(halt));
    mic_core_model core_u (.clk_in(clk), .rst_n_in(rst_n), .vector_req_in(vreq), .halted_in(halt),
        .cmd_in(cmd), .instr_done_out(idone), .sleep_exec_out(sexe), .ret_out(rfs), .pc_out(rpc));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // one single word transfer; called just after a rising edge
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [7:0] wd);
        int k;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr_en;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (hrdy !== 1'b1 && k < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do
        begin
            @(posedge clk);
            k++;
        end
        while (hrdy !== 1'b1 && k < 40);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
        if (k >= 40)
        begin
            err_count++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, x});
    endtask

    // w: 0 vector taken, 1 halted, 2 awake, 3 return issued
    task automatic wt(input int w);
        n = 0;
        ni = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (idone === 1'b1 && vreq !== 1'b1)
                ni++;
        end
        while (!(w == 0 ? vreq === 1'b1 : w == 1 ? halt === 1'b1 : w == 2 ? halt === 1'b0 : rfs === 1'b1) && n < 60);
        if (n >= 60)
        begin
            err_count++;
            results();
        end
    endtask

    always @(posedge clk)
    begin
        if (vreq === 1'b1)
        begin
            n_vec++;
            exp_pc = rpc;
            chk({31'h0, flush}, 32'h1);
            chk({31'h0, push}, 32'h1);
            chk({17'h0, vaddr}, {17'h0, VECTOR_ADDR});
        end
    end

    initial
    begin
        rst_n = 1'b0;
        {hsel, hwrite, pin, t0, srx, stx} = 6'h00;
        {htrans, cmd} = 4'h0;
        {haddr, pchg, p1, p2} = 32'h0;
        hwdata = 32'h0;
        cl = 8'hFF;
        {acc, st, bank, pch} = 32'h5AFF1E6C;
        ptr = '{8'h11, 8'h22, 8'h33, 8'h44};
        ex = '{8'h7E, 8'hFF, PEN2_MASK, PFLG1_WR_MASK, PEN2_MASK};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (e = 0; e < 8; e++)
            rc(8'(e * 4), e == 6 ? {SHADOW_BANK_NUM[4:0], 3'h0} : 8'h00);
        for (e = 0; e < 5; e++)
        begin
            wr(8'(e * 4), e == 0 ? 8'h7F : 8'hFF);
            rc(8'(e * 4), ex[e]);
        end
        wr(8'h3C, 8'hFF);
        rc(8'h3C, 8'h00);
        chk(n_vec, 0);
        for (e = 0; e < 5; e++)
            wr(8'(e * 4), 8'h00);
        $display("registers done, %0d mismatches", err_count);
        {t0, srx, stx} <= 3'h7;
        {p1, p2, pchg} <= 24'hFFFF01;
        @(posedge clk);
        {t0, p1, p2} <= 17'h0;
        rc(ADDR_CORE_CTRL, 8'h05);
        rc(ADDR_PFLG1, 8'hFF);
        rc(ADDR_PFLG2, PEN2_MASK);
        wr(ADDR_CORE_CTRL, 8'h00);
        wr(ADDR_PFLG1, 8'h00);
        rc(ADDR_PFLG1, 8'h30);
        rc(ADDR_CORE_CTRL, 8'h01);
        {pchg, srx, stx} <= 10'h0;
        @(posedge clk);
        rc(ADDR_CORE_CTRL, 8'h00);
        $display("flags done, %0d mismatches", err_count);
        for (e = 0; e < 2; e++)
        begin
            wr(ADDR_OPTION, 8'(e));
            pin <= e[0];
            repeat (8) @(posedge clk);
            wr(ADDR_CORE_CTRL, 8'h00);
            pin <= !e[0];
            repeat (8) @(posedge clk);
            rc(ADDR_CORE_CTRL, 8'h00);
            pin <= e[0];
            repeat (8) @(posedge clk);
            rc(ADDR_CORE_CTRL, 8'h02);
        end
        $display("edges done, %0d mismatches", err_count);
        wr(ADDR_CORE_CTRL, 8'h10);
        pin <= 1'b0;
        repeat (8) @(posedge clk);
        wr(ADDR_CORE_CTRL, 8'h90);
        pin <= 1'b1;
        wt(0);
        chk({31'h0, n >= 12 && n <= 20}, 32'h1);
        rc(ADDR_CORE_CTRL, 8'h12);
        chk({17'h0, ppc}, {17'h0, exp_pc});
        rc(ADDR_SHADOW_BASE + 8'(SH_ACC * 4), acc);
        rc(ADDR_SHADOW_BASE + 8'(SH_STATUS * 4), st & STATUS_SAVE_MASK);
        rc(ADDR_SHADOW_BASE + 8'(SH_BANK * 4), bank);
        rc(ADDR_SHADOW_BASE + 8'(SH_PC_HIGH * 4), pch);
        wr(ADDR_SHADOW_BASE, 8'hC3);
        rc(ADDR_SHADOW_BASE, 8'hC3);
        wr(ADDR_CORE_CTRL, 8'h10);
        cmd <= 2'h2;
        @(posedge clk);
        cmd <= 2'h0;
        wt(3);
        chk({31'h0, rest}, 32'h1);
        chk({24'h0, sh[SH_ACC]}, 32'h000000C3);
        rc(ADDR_CORE_CTRL, 8'h90);
        $display("vector and context done, %0d mismatches", err_count);
        wr(ADDR_CORE_CTRL, 8'hA0);
        t0 <= 1'b1;
        @(posedge clk);
        t0 <= 1'b0;
        wt(0);
        chk({31'h0, n <= 16}, 32'h1);
        wr(ADDR_CORE_CTRL, 8'h00);
        wr(ADDR_PEN1, 8'h01);
        wr(ADDR_CORE_CTRL, 8'h80);
        p1 <= 8'h01;
        @(posedge clk);
        p1 <= 8'h00;
        i = n_vec;
        repeat (24) @(posedge clk);
        chk(n_vec, i);
        wr(ADDR_CORE_CTRL, 8'hC0);
        wt(0);
        chk({31'h0, n <= 16}, 32'h1);
        wr(ADDR_PFLG1, 8'h00);
        wr(ADDR_PEN1, 8'h00);
        $display("latency and groups done, %0d mismatches", err_count);
        for (e = 0; e < 2; e++)
        begin
            wr(ADDR_CORE_CTRL, e == 0 ? 8'h10 : 8'h90);
            pin <= 1'b0;
            cmd <= 2'h1;
            @(posedge clk);
            cmd <= 2'h0;
            wt(1);
            pin <= 1'b1;
            wt(2);
            chk({31'h0, n <= 20}, 32'h1);
            i = n_vec;
            if (e == 0)
            begin
                repeat (24) @(posedge clk);
                chk(n_vec, i);
            end
            else
            begin
                wt(0);
                chk({31'h0, ni >= 1}, 32'h1);
            end
        end
        // a clocked source must not wake the core, a clockless one must
        wr(ADDR_CORE_CTRL, 8'h00);
        wr(ADDR_PEN1, 8'h01);
        cl <= 8'hFE;
        cmd <= 2'h1;
        @(posedge clk);
        cmd <= 2'h0;
        wt(1);
        p1 <= 8'h01;
        @(posedge clk);
        p1 <= 8'h00;
        repeat (24) @(posedge clk);
        chk({31'h0, halt}, 32'h1);
        cl <= 8'hFF;
        wt(2);
        chk({31'h0, n <= 4}, 32'h1);
        $display("sleep done, %0d mismatches", err_count);
        results();
    end
endmodule
